/* logic/sfc_defs.svh */
// Constants of the serial flash sequencer: sizes, opcodes, counts, reset values
// Assumes inclusion by bare name from files under logic/
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define SFC_CACHE_BYTES      32
`define SFC_CACHE_AW         5
`define SFC_CACHE_LEN_FULL   6'h20
`define SFC_BUF_BYTES        8
`define SFC_BUF_AW           3
`define SFC_BUF_LAST         8'h08
`define SFC_HDR_LAST         8'h04

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define SFC_OP_FAST_READ          8'h0b
`define SFC_OP_DUAL_READ          8'h3b
`define SFC_SECTOR_WIPE_OP        8'h20
`define SFC_SMALL_BLOCK_WIPE_OP   8'h52
`define SFC_LARGE_BLOCK_WIPE_OP   8'hd8
`define SFC_BYTE_PROGRAM_OP       8'h02
`define SFC_PART_IDENTITY_READ_OP 8'h9f
`define SFC_DONT_CARE             8'hff

// ----------------------------------------------------------------------------
// Serial timing and reset values
// ----------------------------------------------------------------------------
`define SFC_BITS_SINGLE      4'h8
`define SFC_BITS_DUAL        4'h4
`define SFC_PH_LAST          2'h3
`define SFC_COUNT_RESET      8'h00

`endif

/* logic/sfc_pkg.sv */
// Types shared by the serial flash sequencer modules
// Assumes nothing beyond a SystemVerilog compiler
package sfc_pkg;

  // --------------------------------------------------------------------------
  // State machines
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FHDR  = 3'b001,
    ST_FDATA = 3'b010,
    ST_FEND  = 3'b011,
    ST_CXFER = 3'b100,
    ST_CEND  = 3'b101
  } sfc_state_type;

  typedef enum logic [1:0] {
    LK_IDLE  = 2'b00,
    LK_SHIFT = 2'b01
  } sfc_link_state_type;

endpackage : sfc_pkg

/* logic/sfc_link_if.sv */
// Byte handshake between the core-clock sequencer and the link-clock shifter
// Assumes req_tog/ack_tog are toggles; op_end, op_dual and tx_byte hold still while pending; rx_byte shifts until ack
interface sfc_link_if;
  logic       req_tog;
  logic       op_end;
  logic       op_dual;
  logic [7:0] tx_byte;
  logic       ack_tog;
  logic [7:0] rx_byte;

  modport core (
    output req_tog,
    output op_end,
    output op_dual,
    output tx_byte,
    input  ack_tog,
    input  rx_byte
  );

  modport engine (
    input  req_tog,
    input  op_end,
    input  op_dual,
    input  tx_byte,
    output ack_tog,
    output rx_byte
  );
endinterface : sfc_link_if

/* logic/sfc_shift_engine.sv */
// Link-clock byte shifter: drives select, serial clock and data pins
// Assumes the link clock is free running; serial clock is a quarter of it
`include "sfc_defs.svh"

module sfc_shift_engine (
  input  wire logic   link_clk,
  input  wire logic   reset_n,
  sfc_link_if.engine  lnk,
  input  wire logic   serial_in_line,
  input  wire logic   dq0_in,
  output logic        sel_n,
  output logic        sck,
  output logic        dq0_out,
  output logic        dq0_oe
);

  // --------------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------------
  logic rst_meta, rst_sync;
  logic req_meta, req_sync;
  logic si_meta, si_sync;
  logic d0_meta, d0_sync;

  always_ff @(posedge link_clk) begin
    rst_meta <= reset_n;
    rst_sync <= rst_meta;
    req_meta <= lnk.req_tog;
    req_sync <= req_meta;
    si_meta  <= serial_in_line;
    si_sync  <= si_meta;
    d0_meta  <= dq0_in;
    d0_sync  <= d0_meta;
  end

  // --------------------------------------------------------------------------
  // Shifter
  // --------------------------------------------------------------------------
  sfc_pkg::sfc_link_state_type state, next_state;
  logic [1:0] ph, next_ph;
  logic [3:0] bits, next_bits;
  logic [7:0] shreg, next_shreg;
  logic       req_seen, next_req_seen;
  logic       ack, next_ack;
  logic       dual, next_dual;
  logic       next_sel_n, next_sck, next_dq0_out, next_dq0_oe;

  assign lnk.ack_tog = ack;
  assign lnk.rx_byte = shreg;

  always_comb begin
    next_state    = state;
    next_ph       = ph;
    next_bits     = bits;
    next_shreg    = shreg;
    next_req_seen = req_seen;
    next_ack      = ack;
    next_dual     = dual;
    next_sel_n    = sel_n;
    next_sck      = sck;
    next_dq0_out  = dq0_out;
    next_dq0_oe   = dq0_oe;
    case (state)
      sfc_pkg::LK_IDLE: begin
        if (req_sync != req_seen) begin
          next_req_seen = req_sync;
          if (lnk.op_end) begin
            next_sel_n  = 1'b1;
            next_dq0_oe = 1'b0;
            next_ack    = ~ack;
          end else begin
            next_sel_n   = 1'b0;
            next_state   = sfc_pkg::LK_SHIFT;
            next_ph      = 2'h0;
            next_dual    = lnk.op_dual;
            next_bits    = lnk.op_dual ? `SFC_BITS_DUAL : `SFC_BITS_SINGLE;
            next_shreg   = lnk.tx_byte;
            next_dq0_out = lnk.tx_byte[7];
            next_dq0_oe  = ~lnk.op_dual;
          end
        end
      end
      sfc_pkg::LK_SHIFT: begin
        next_ph  = ph + 2'h1;
        next_sck = (ph == 2'h1) || (ph == 2'h2);
        if (ph == `SFC_PH_LAST) begin
          if (dual) begin
            next_shreg = {shreg[5:0], si_sync, d0_sync};
          end else begin
            next_shreg = {shreg[6:0], si_sync};
          end
          next_dq0_out = shreg[6];
          next_bits    = bits - 4'h1;
          if (bits == 4'h1) begin
            next_state = sfc_pkg::LK_IDLE;
            next_ack   = ~ack;
          end
        end
      end
      default: begin
        next_state = sfc_pkg::LK_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (!rst_sync) begin
      state    <= sfc_pkg::LK_IDLE;
      ph       <= 2'h0;
      bits     <= 4'h0;
      shreg    <= 8'h00;
      req_seen <= 1'b0;
      ack      <= 1'b0;
      dual     <= 1'b0;
      sel_n    <= 1'b1;
      sck      <= 1'b0;
      dq0_out  <= 1'b0;
      dq0_oe   <= 1'b0;
    end else begin
      state    <= next_state;
      ph       <= next_ph;
      bits     <= next_bits;
      shreg    <= next_shreg;
      req_seen <= next_req_seen;
      ack      <= next_ack;
      dual     <= next_dual;
      sel_n    <= next_sel_n;
      sck      <= next_sck;
      dq0_out  <= next_dq0_out;
      dq0_oe   <= next_dq0_oe;
    end
  end

endmodule : sfc_shift_engine

/* logic/sfc_flash_seq.sv */
// Serial flash sequencer: fetch path with 32-byte cache and buffered command path
// Assumes control inputs come from logic on CLK; flash pins pass the link shifter
`include "sfc_defs.svh"

// Behaviour
// - Jump loads cache base; 32-byte cache kept
// - Each sequential byte cached, length plus one
// - Past 32 bytes, base follows newest byte
// - Jump inside cached range answered next clock
// - Eight-byte command, response buffers, byte count
// - Launch bit drops select when count is nonzero, self-clears
// - Eight serial clocks per counted byte
// - First eight bytes after opcode captured into responses
// - Beyond buffered bytes, send don't-care
// - Erase: four bytes, select raised after
// - Byte program: five bytes in order
// - Single opcode: count one, eight bits
// - Identity read: opcode plus three dummy bytes
// - Command path only when running internally
// - Fetch sends fast-read (dual-read if dual) opcode, address, dummy
// - Sequential fetches continue; other misses raise select, cache hits leave it low
// - Dual fetch at slow rate, four clocks
module sfc_flash_seq (
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire logic       LINK_CLK,
  input  wire logic       EXEC_EXTERNAL,
  input  wire logic       DUAL_MODE,
  input  wire logic       FAST_RATE,
  input  wire logic       FETCH_REQ,
  input  wire logic [23:0] FETCH_ADDR,
  output logic            FETCH_READY,
  output logic [7:0]      FETCH_DATA,
  output logic            FETCH_FROM_CACHE,
  input  wire logic       CMD_WR,
  input  wire logic [2:0] CMD_INDEX,
  input  wire logic [7:0] CMD_WDATA,
  input  wire logic       COUNT_WR,
  input  wire logic [7:0] COUNT_WDATA,
  input  wire logic       LAUNCH_SET,
  output logic            LAUNCH_BIT,
  output logic            CMD_BUSY,
  input  wire logic [2:0] RESP_INDEX,
  output logic [7:0]      RESP_RDATA,
  output logic            SPI_SEL_N,
  output logic            SPI_CLK,
  output logic            SPI_DQ0_O,
  output logic            SPI_DQ0_OE,
  input  wire logic       SPI_DQ0_I,
  input  wire logic       SERIAL_IN_LINE
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic cache_hit(input logic [23:0] a, input logic [23:0] b,
                                     input logic [5:0] n);
    logic [24:0] off;
    off       = {1'b0, a} - {1'b0, b};
    cache_hit = (a >= b) && (off < {19'h0, n});
  endfunction : cache_hit

  function automatic logic [7:0] hdr_byte(input logic [7:0] idx, input logic dual,
                                          input logic [23:0] a);
    case (idx[2:0])
      3'h0:    hdr_byte = dual ? `SFC_OP_DUAL_READ : `SFC_OP_FAST_READ;
      3'h1:    hdr_byte = a[23:16];
      3'h2:    hdr_byte = a[15:8];
      3'h3:    hdr_byte = a[7:0];
      default: hdr_byte = `SFC_DONT_CARE;
    endcase
  endfunction : hdr_byte

  // --------------------------------------------------------------------------
  // Link shifter and ack synchroniser
  // --------------------------------------------------------------------------
  sfc_link_if lnk ();

  sfc_shift_engine u_engine (
    .link_clk       (LINK_CLK),
    .reset_n        (RESET_N),
    .lnk            (lnk.engine),
    .serial_in_line (SERIAL_IN_LINE),
    .dq0_in         (SPI_DQ0_I),
    .sel_n          (SPI_SEL_N),
    .sck            (SPI_CLK),
    .dq0_out        (SPI_DQ0_O),
    .dq0_oe         (SPI_DQ0_OE)
  );

  logic ack_meta, ack_sync;

  always_ff @(posedge CLK) begin
    ack_meta <= lnk.ack_tog;
    ack_sync <= ack_meta;
  end

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [7:0] cache [`SFC_CACHE_BYTES];
  logic [7:0] cmd_buf [`SFC_BUF_BYTES];
  logic [7:0] resp_buf [`SFC_BUF_BYTES];

  logic                    cache_we, resp_we;
  logic [`SFC_CACHE_AW-1:0] cache_wa;
  logic [`SFC_BUF_AW-1:0]   resp_wa;
  logic [7:0]              cache_wd;

  always_ff @(posedge CLK) begin
    if (cache_we) begin
      cache[cache_wa] <= cache_wd;
    end
    if (resp_we) begin
      resp_buf[resp_wa] <= lnk.rx_byte;
    end
    if (CMD_WR) begin
      cmd_buf[CMD_INDEX] <= CMD_WDATA;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  sfc_pkg::sfc_state_type state, next_state;
  logic [7:0]  byte_idx, next_byte_idx;
  logic [7:0]  byte_count, next_byte_count;
  logic        req_tog, next_req_tog;
  logic        op_end, next_op_end;
  logic        op_dual, next_op_dual;
  logic [7:0]  tx_byte, next_tx_byte;
  logic        ack_seen;
  logic [23:0] fetch_addr, next_fetch_addr;
  logic [23:0] last_addr, next_last_addr;
  logic        stream_open, next_stream_open;
  logic        fetch_dual, next_fetch_dual;
  logic        restart, next_restart;
  logic [23:0] cache_base, next_cache_base;
  logic [5:0]  cache_len, next_cache_len;
  logic        next_fetch_ready, next_from_cache, next_launch, next_cmd_busy;
  logic [7:0]  next_fetch_data;
  logic        ack_event, issue, iss_end, iss_dual, start_hdr;
  logic [7:0]  iss_byte, idx_inc;
  logic [23:0] hdr_addr;

  assign ack_event = ack_sync != ack_seen;
  assign idx_inc   = byte_idx + 8'h01;

  assign lnk.req_tog = req_tog;
  assign lnk.op_end  = op_end;
  assign lnk.op_dual = op_dual;
  assign lnk.tx_byte = tx_byte;

  always_comb begin
    next_state       = state;
    next_byte_idx    = byte_idx;
    next_byte_count  = COUNT_WR ? COUNT_WDATA : byte_count;
    next_req_tog     = req_tog;
    next_op_end      = op_end;
    next_op_dual     = op_dual;
    next_tx_byte     = tx_byte;
    next_fetch_addr  = fetch_addr;
    next_last_addr   = last_addr;
    next_stream_open = stream_open;
    next_fetch_dual  = fetch_dual;
    next_restart     = restart;
    next_cache_base  = cache_base;
    next_cache_len   = cache_len;
    next_fetch_ready = 1'b0;
    next_from_cache  = 1'b0;
    next_fetch_data  = FETCH_DATA;
    next_launch      = LAUNCH_BIT | LAUNCH_SET;
    next_cmd_busy    = CMD_BUSY;
    cache_we         = 1'b0;
    cache_wa         = fetch_addr[`SFC_CACHE_AW-1:0];
    cache_wd         = lnk.rx_byte;
    resp_we          = 1'b0;
    resp_wa          = byte_idx[`SFC_BUF_AW-1:0] - 3'h1;
    issue            = 1'b0;
    iss_end          = 1'b0;
    iss_dual         = 1'b0;
    iss_byte         = `SFC_DONT_CARE;
    start_hdr        = 1'b0;
    hdr_addr         = fetch_addr;
    case (state)
      sfc_pkg::ST_IDLE: begin
        if (stream_open && !EXEC_EXTERNAL) begin
          issue        = 1'b1;
          iss_end      = 1'b1;
          next_restart = 1'b0;
          next_state   = sfc_pkg::ST_FEND;
        end else if (LAUNCH_BIT && !EXEC_EXTERNAL) begin
          next_launch    = LAUNCH_SET;
          next_cache_len = 6'h00;
          if (byte_count != 8'h00) begin
            next_cmd_busy = 1'b1;
            next_byte_idx = 8'h00;
            issue         = 1'b1;
            iss_byte      = cmd_buf[0];
            next_state    = sfc_pkg::ST_CXFER;
          end
        end else if (FETCH_REQ && EXEC_EXTERNAL) begin
          if (cache_hit(FETCH_ADDR, cache_base, cache_len)) begin
            next_fetch_ready = 1'b1;
            next_from_cache  = 1'b1;
            next_fetch_data  = cache[FETCH_ADDR[`SFC_CACHE_AW-1:0]];
          end else if (stream_open && FETCH_ADDR == last_addr + 24'h1) begin
            next_fetch_addr = FETCH_ADDR;
            issue           = 1'b1;
            iss_dual        = fetch_dual;
            next_state      = sfc_pkg::ST_FDATA;
          end else if (stream_open) begin
            next_fetch_addr = FETCH_ADDR;
            issue           = 1'b1;
            iss_end         = 1'b1;
            next_restart    = 1'b1;
            next_state      = sfc_pkg::ST_FEND;
          end else begin
            start_hdr = 1'b1;
            hdr_addr  = FETCH_ADDR;
          end
        end
      end
      sfc_pkg::ST_FHDR: begin
        if (ack_event) begin
          issue = 1'b1;
          if (byte_idx == `SFC_HDR_LAST) begin
            iss_dual   = fetch_dual;
            next_state = sfc_pkg::ST_FDATA;
          end else begin
            next_byte_idx = idx_inc;
            iss_byte      = hdr_byte(idx_inc, fetch_dual, fetch_addr);
          end
        end
      end
      sfc_pkg::ST_FDATA: begin
        if (ack_event) begin
          cache_we = 1'b1;
          if (cache_len < `SFC_CACHE_LEN_FULL) begin
            next_cache_len = cache_len + 6'h01;
          end else begin
            next_cache_base = cache_base + 24'h1;
          end
          next_fetch_ready = 1'b1;
          next_fetch_data  = lnk.rx_byte;
          next_last_addr   = fetch_addr;
          next_stream_open = 1'b1;
          next_state       = sfc_pkg::ST_IDLE;
        end
      end
      sfc_pkg::ST_FEND: begin
        if (ack_event) begin
          next_stream_open = 1'b0;
          if (restart) begin
            start_hdr = 1'b1;
          end else begin
            next_state = sfc_pkg::ST_IDLE;
          end
        end
      end
      sfc_pkg::ST_CXFER: begin
        if (ack_event) begin
          resp_we = (byte_idx != 8'h00) && (byte_idx <= `SFC_BUF_LAST);
          issue   = 1'b1;
          if (idx_inc == byte_count) begin
            iss_end    = 1'b1;
            next_state = sfc_pkg::ST_CEND;
          end else begin
            next_byte_idx = idx_inc;
            if (idx_inc < `SFC_BUF_LAST) begin
              iss_byte = cmd_buf[idx_inc[`SFC_BUF_AW-1:0]];
            end else begin
              iss_byte = `SFC_DONT_CARE;
            end
          end
        end
      end
      sfc_pkg::ST_CEND: begin
        if (ack_event) begin
          next_cmd_busy = 1'b0;
          next_state    = sfc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = sfc_pkg::ST_IDLE;
      end
    endcase
    if (start_hdr) begin
      next_fetch_addr = hdr_addr;
      next_cache_base = hdr_addr;
      next_cache_len  = 6'h00;
      next_fetch_dual = DUAL_MODE && !FAST_RATE;
      next_byte_idx   = 8'h00;
      issue           = 1'b1;
      iss_byte        = hdr_byte(8'h00, DUAL_MODE && !FAST_RATE, hdr_addr);
      next_state      = sfc_pkg::ST_FHDR;
    end
    if (issue) begin
      next_req_tog = ~req_tog;
      next_op_end  = iss_end;
      next_op_dual = iss_dual;
      next_tx_byte = iss_byte;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state            <= sfc_pkg::ST_IDLE;
      byte_idx         <= 8'h00;
      byte_count       <= `SFC_COUNT_RESET;
      req_tog          <= 1'b0;
      op_end           <= 1'b0;
      op_dual          <= 1'b0;
      tx_byte          <= 8'h00;
      ack_seen         <= 1'b0;
      fetch_addr       <= 24'h0;
      last_addr        <= 24'h0;
      stream_open      <= 1'b0;
      fetch_dual       <= 1'b0;
      restart          <= 1'b0;
      cache_base       <= 24'h0;
      cache_len        <= 6'h00;
      FETCH_READY      <= 1'b0;
      FETCH_FROM_CACHE <= 1'b0;
      FETCH_DATA       <= 8'h00;
      LAUNCH_BIT       <= 1'b0;
      CMD_BUSY         <= 1'b0;
      RESP_RDATA       <= 8'h00;
    end else begin
      state            <= next_state;
      byte_idx         <= next_byte_idx;
      byte_count       <= next_byte_count;
      req_tog          <= next_req_tog;
      op_end           <= next_op_end;
      op_dual          <= next_op_dual;
      tx_byte          <= next_tx_byte;
      ack_seen         <= ack_sync;
      fetch_addr       <= next_fetch_addr;
      last_addr        <= next_last_addr;
      stream_open      <= next_stream_open;
      fetch_dual       <= next_fetch_dual;
      restart          <= next_restart;
      cache_base       <= next_cache_base;
      cache_len        <= next_cache_len;
      FETCH_READY      <= next_fetch_ready;
      FETCH_FROM_CACHE <= next_from_cache;
      FETCH_DATA       <= next_fetch_data;
      LAUNCH_BIT       <= next_launch;
      CMD_BUSY         <= next_cmd_busy;
      RESP_RDATA       <= resp_buf[RESP_INDEX];
    end
  end

endmodule : sfc_flash_seq

/* tb/sfc_flash_seq_monitor.sv */
// Checker for the serial flash sequencer top ports
// Assumes a bind onto sfc_flash_seq; all checks sampled on CLK
module sfc_flash_seq_monitor (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic EXEC_EXTERNAL,
  input wire logic FETCH_REQ,
  input wire logic FETCH_READY,
  input wire logic FETCH_FROM_CACHE,
  input wire logic LAUNCH_SET,
  input wire logic LAUNCH_BIT,
  input wire logic CMD_BUSY,
  input wire logic SPI_SEL_N,
  input wire logic SPI_CLK
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence launch_taken_s;
    $rose(CMD_BUSY);
  endsequence
  sequence select_low_s;
    ##[1:64] !SPI_SEL_N;
  endsequence
  launch_cause_a: assert property (launch_taken_s |-> $past(LAUNCH_BIT) &&
    !$past(EXEC_EXTERNAL)) else $error("Command start without launch while internal");
  launch_clear_a: assert property (launch_taken_s |-> !LAUNCH_BIT || $past(LAUNCH_SET))
    else $error("Launch bit not cleared at start");
  select_drop_a: assert property (launch_taken_s |-> select_low_s)
    else $error("Select not lowered after launch");
  hit_ready_a: assert property (FETCH_FROM_CACHE |-> FETCH_READY)
    else $error("Cache flag without ready");
  hit_quick_a: assert property (FETCH_FROM_CACHE |-> $past(FETCH_REQ) && $past(EXEC_EXTERNAL))
    else $error("Cache answer not one clock after request");
  ready_pulse_a: assert property (FETCH_READY |=> !FETCH_READY)
    else $error("Ready longer than one cycle");
  busy_end_a: assert property ($fell(CMD_BUSY) |-> SPI_SEL_N)
    else $error("Busy ended with select low");
  busy_hold_a: assert property (CMD_BUSY && !SPI_SEL_N |=> CMD_BUSY)
    else $error("Busy dropped during transfer");
  clock_idle_a: assert property (SPI_SEL_N |-> !SPI_CLK)
    else $error("Serial clock high while deselected");
endmodule : sfc_flash_seq_monitor

/* tb/sfc_flash_model.sv */
// Behavioural serial flash on the far side of the sequencer
// Assumes mode 0: samples on rising serial clock, shifts on falling
module sfc_flash_model (
  input  wire logic sel_n,
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic dual,
  output logic      miso,
  output logic      io0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx [0:15];
  logic [7:0] shreg;
  logic [7:0] tx;
  int         nbit = 0;
  initial miso = 1'b0;
  initial io0 = 1'b0;
  // Byte k returned is k xor 3c, MSB first
  always @(negedge sel_n) begin
    nbit = 0;
    miso = 1'b0;
  end
  // Dual data after the header: bit pairs on miso and io0
  always @(negedge sck) if (!sel_n) begin
    if (dual && nbit >= 40) begin
      tx   = 8'(5 + (nbit - 40) / 4) ^ 8'h3c;
      miso = tx[3'(7 - 2 * (nbit % 4))];
      io0  = tx[3'(6 - 2 * (nbit % 4))];
    end else begin
      tx   = 8'(nbit / 8) ^ 8'h3c;
      miso = tx[3'(7 - nbit % 8)];
    end
  end
  always @(posedge sck) if (!sel_n) begin
    shreg = {shreg[6:0], mosi};
    nbit  = nbit + 1;
    if (nbit % 8 == 0 && nbit <= 128) rx[nbit / 8 - 1] = shreg;
  end
  // Released line shows the inverse of its last bit
  always @(posedge sel_n) miso = ~miso;
endmodule : sfc_flash_model

/* tb/test_sfc_flash_seq.sv */
// Self-checking bench for the serial flash sequencer
// Assumes the design, its monitor and the flash model are compiled first
module test_sfc_flash_seq;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLK, RESET_N, LINK_CLK, EXEC_EXTERNAL, FETCH_REQ, FETCH_READY;
  logic        FETCH_FROM_CACHE, CMD_WR, COUNT_WR, LAUNCH_SET, LAUNCH_BIT, CMD_BUSY;
  logic        SPI_SEL_N, SPI_CLK, SPI_DQ0_O, SPI_DQ0_OE, miso, io0, DUAL_MODE, FAST_RATE;
  logic [23:0] FETCH_ADDR;
  logic [7:0]  FETCH_DATA, CMD_WDATA, COUNT_WDATA, RESP_RDATA;
  logic [2:0]  CMD_INDEX, RESP_INDEX;
  int          bad_count = 0;
  int          n_checks = 0;
  always #2 CLK = ~CLK;
  initial begin
    LINK_CLK = 1'b0;
    #7;
    forever #16 LINK_CLK = ~LINK_CLK;
  end
  sfc_flash_seq uut (.CLK, .RESET_N, .LINK_CLK, .EXEC_EXTERNAL, .DUAL_MODE,
    .FAST_RATE, .FETCH_REQ, .FETCH_ADDR, .FETCH_READY, .FETCH_DATA, .FETCH_FROM_CACHE,
    .CMD_WR, .CMD_INDEX, .CMD_WDATA, .COUNT_WR, .COUNT_WDATA, .LAUNCH_SET, .LAUNCH_BIT,
    .CMD_BUSY, .RESP_INDEX, .RESP_RDATA, .SPI_SEL_N, .SPI_CLK, .SPI_DQ0_O, .SPI_DQ0_OE,
    .SPI_DQ0_I(SPI_DQ0_OE ? SPI_DQ0_O : io0), .SERIAL_IN_LINE(miso));
  sfc_flash_model flash (.sel_n(SPI_SEL_N), .sck(SPI_CLK), .mosi(SPI_DQ0_O),
    .dual(DUAL_MODE && !FAST_RATE), .miso, .io0);
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic step(inout int k);
    @(posedge CLK);
    #1;
    k++;
    if (k > 8000) begin
      bad_count++;
      report_and_stop();
    end
  endtask : step
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    #1;
    while (CMD_BUSY !== lvl) step(k);
  endtask : wait_busy
  task automatic fetch(input logic [23:0] a, input int b, input logic hit);
    int k;
    k = 0;
    @(posedge CLK);
    FETCH_REQ  <= 1'b1;
    FETCH_ADDR <= a;
    @(posedge CLK);
    FETCH_REQ <= 1'b0;
    #1;
    while (FETCH_READY !== 1'b1) step(k);
    check(FETCH_DATA, 8'(b) ^ 8'h3c);
    check({7'h00, FETCH_FROM_CACHE}, {7'h00, hit});
    if (hit) check(8'(k), 8'h00);
  endtask : fetch
  task automatic launch(input logic [7:0] n);
    @(posedge CLK);
    CMD_WR      <= 1'b0;
    COUNT_WR    <= 1'b1;
    COUNT_WDATA <= n;
    LAUNCH_SET  <= 1'b1;
    @(posedge CLK);
    COUNT_WR   <= 1'b0;
    LAUNCH_SET <= 1'b0;
  endtask : launch
  task automatic run_cmd(input int n, input logic [63:0] b, input logic rd);
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK);
      CMD_WR    <= 1'b1;
      CMD_INDEX <= 3'(i);
      CMD_WDATA <= b[8*i +: 8];
    end
    launch(8'(n));
    wait_busy(1'b1);
    check({7'h00, LAUNCH_BIT}, 8'h00);
    wait_busy(1'b0);
    check(8'(flash.nbit), 8'(8 * n));
    for (int i = 0; i < n; i++) check(flash.rx[i], i < 8 ? b[8*i +: 8] : 8'hff);
    for (int j = 0; j < 8; j++) if (rd && j < n - 1) begin
      @(posedge CLK);
      RESP_INDEX <= 3'(j);
      @(posedge CLK);
      #1;
      check(RESP_RDATA, 8'(j + 1) ^ 8'h3c);
    end
  endtask : run_cmd
  task automatic fetch_run();
    for (int i = 0; i < 40; i++) fetch(24'h012340 + 24'(i), 5 + i, 1'b0);
    check(flash.rx[0], 8'h0b);
    check(flash.rx[3], 8'h40);
    fetch(24'h012348, 13, 1'b1);
    fetch(24'h012347, 5, 1'b0);
    check(flash.rx[3], 8'h47);
  endtask : fetch_run
  task automatic dual_run();
    @(posedge CLK);
    DUAL_MODE <= 1'b1;
    fetch(24'h012400, 5, 1'b0);
    check(flash.rx[0], 8'h0b);
    @(posedge CLK);
    FAST_RATE <= 1'b0;
    fetch(24'h012500, 5, 1'b0);
    fetch(24'h012501, 6, 1'b0);
    check(flash.rx[0], 8'h3b);
    check(8'(flash.nbit), 8'h30);
    @(posedge CLK);
    DUAL_MODE <= 1'b0;
  endtask : dual_run
  task automatic cmd_run();
    logic [7:0] ops [4] = '{8'h20, 8'h52, 8'hd8, 8'h02};
    launch(8'h01);
    repeat (20) @(posedge CLK);
    #1;
    check({6'h00, LAUNCH_BIT, CMD_BUSY}, 8'h02);
    @(posedge CLK);
    EXEC_EXTERNAL <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    run_cmd(4, 64'h9f, 1'b1);
    foreach (ops[i]) run_cmd(i == 3 ? 5 : 4, {24'h0, 8'ha5, 24'h563412, ops[i]}, 1'b0);
    run_cmd(1, 64'h5a, 1'b0);
    run_cmd(10, 64'h0807060504030201, 1'b1);
    launch(8'h00);
    repeat (20) @(posedge CLK);
    #1;
    check({5'h00, SPI_SEL_N, LAUNCH_BIT, CMD_BUSY}, 8'h04);
  endtask : cmd_run
  initial begin
    CLK           = 1'b0;
    RESET_N       = 1'b0;
    EXEC_EXTERNAL = 1'b1;
    DUAL_MODE     = 1'b0;
    FAST_RATE     = 1'b1;
    FETCH_REQ     = 1'b0;
    FETCH_ADDR    = 24'h000000;
    CMD_WR        = 1'b0;
    CMD_INDEX     = 3'h0;
    CMD_WDATA     = 8'h00;
    COUNT_WR      = 1'b0;
    COUNT_WDATA   = 8'h00;
    LAUNCH_SET    = 1'b0;
    RESP_INDEX    = 3'h0;
    repeat (8) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (40) @(posedge CLK);
    #1;
    check({5'h00, SPI_SEL_N, LAUNCH_BIT, CMD_BUSY}, 8'h04);
    fetch_run();
    dual_run();
    cmd_run();
    report_and_stop();
  end
endmodule : test_sfc_flash_seq
bind sfc_flash_seq sfc_flash_seq_monitor mon (.CLK, .RESET_N, .EXEC_EXTERNAL, .FETCH_REQ,
  .FETCH_READY, .FETCH_FROM_CACHE, .LAUNCH_SET, .LAUNCH_BIT, .CMD_BUSY, .SPI_SEL_N, .SPI_CLK);
